// File: trig_pkg.sv
package trig_pkg;

   localparam int CYCLE_W     = 6;
   localparam int MT_W        = 14;
   localparam int MSG_BUFS    = 128;
   localparam int MRAM_BYTES  = 8192;
   localparam int BUF_IDX_W   = 7;
   localparam int CYCLE_MASK_W = 6;

   localparam logic [MT_W-1:0]    MT_RESET    = 14'h0000;
   localparam logic [CYCLE_W-1:0] CYCLE_RESET = 6'h00;

   // Stop-watch source select encoding
   typedef enum logic [1:0] {
      SW_SRC_SOFT = 2'b00,
      SW_SRC_IRQ0 = 2'b01,
      SW_SRC_IRQ1 = 2'b10,
      SW_SRC_EXT  = 2'b11
   } sw_src_t;

   typedef enum logic [1:0] {
      IB_FILL_REQ  = 2'b00,
      IB_WAIT_DONE = 2'b01,
      IB_TRANSFER  = 2'b10
   } ib_state_t;

   typedef struct packed {
      logic                    run;
      logic                    continuous;
      logic [CYCLE_MASK_W-1:0] cycle_code;
      logic [MT_W-1:0]         mt_offset;
   } tz_cfg_t;

   typedef struct packed {
      logic [CYCLE_W-1:0] cycle;
      logic [MT_W-1:0]    macrotick;
   } cycle_time_t;

endpackage : trig_pkg

// File: stop_watch.sv
`timescale 1ns/1ps
module stop_watch (
   input  wire logic                  i_core_clk,
   input  wire logic                  i_rst_n,
   input  wire trig_pkg::sw_src_t     i_src_sel,
   input  wire logic                  i_soft_trig,
   input  wire logic                  i_irq_line_zero,
   input  wire logic                  i_irq_line_one,
   input  wire logic                  i_ext_trig,
   input  wire trig_pkg::cycle_time_t i_now,
   output trig_pkg::cycle_time_t      o_stamp,
   output logic                       o_captured
);
   import trig_pkg::*;

   logic irq0_q;
   logic irq1_q;
   logic fire;

   // Interrupt lines are levels; only a rising edge counts as an event
   always_comb begin
      case (i_src_sel)
         SW_SRC_SOFT: fire = i_soft_trig;
         SW_SRC_IRQ0: fire = i_irq_line_zero & ~irq0_q;
         SW_SRC_IRQ1: fire = i_irq_line_one & ~irq1_q;
         default:     fire = i_ext_trig;
      endcase
   end // [RULE6]

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         irq0_q <= 1'b0;
         irq1_q <= 1'b0;
      end else begin
         irq0_q <= i_irq_line_zero;
         irq1_q <= i_irq_line_one;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_stamp    <= '0;
         o_captured <= 1'b0;
      end else begin
         o_captured <= fire;
         if (fire) begin
            o_stamp <= i_now; // [RULE7] [RULE19]
         end
      end
   end

   chk_sw_capture: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE7]
      fire |=> (o_stamp == $past(i_now)) && o_captured)
      else $error("stop-watch did not store time");

endmodule // stop_watch

// File: comm_controller_trigger_unit.sv
`timescale 1ns/1ps
// Summary of operation
// RULE1: one pulse per timer-zero interrupt assertion
// RULE2: timer zero compares absolute macrotick
// RULE3: start/stop, single-shot or continuous mode
// RULE4: cycle-qualified; raises interrupt and trigger
// RULE5: expiry point is macrotick offset
// RULE6: stop-watch from soft, irq0, irq1, external
// RULE7: capture cycle number and macrotick
// RULE8: fill request asks DMA for message
// RULE9: command-done input means request written
// RULE10: software gives first command-done trigger
// RULE11: DMA chains second channel via mux
// RULE12: second channel asserts command-done
// RULE13: second channel interrupts application
// RULE14: input/output staging buffers hold messages
// RULE15: 128 buffers in 8 KB message RAM
// RULE16: command moves staging into message buffer
// RULE17: re-request fill once staging is free
// RULE18: trigger pulse is one clock wide
// RULE19: new capture overwrites old stamp
module comm_controller_trigger_unit #(
   parameter int XFER_CYCLES = 4
)(
   input  wire logic                           i_core_clk,
   input  wire logic                           i_rst_n,
   input  wire trig_pkg::cycle_time_t          i_now,
   input  wire trig_pkg::tz_cfg_t              i_tz_cfg,
   input  wire logic                           i_tz_irq_clear,
   input  wire trig_pkg::sw_src_t              i_sw_src_sel,
   input  wire logic                           i_sw_soft_trig,
   input  wire logic                           i_irq_line_zero,
   input  wire logic                           i_irq_line_one,
   input  wire logic                           i_sw_ext_trig,
   input  wire logic                           i_inbuf_cmd_done_in,
   input  wire logic [trig_pkg::BUF_IDX_W-1:0] i_inbuf_target,
   output logic                                o_timer_zero_pulse_out,
   output logic                                o_tz_irq,
   output logic                                o_tz_running,
   output trig_pkg::cycle_time_t               o_sw_stamp,
   output logic                                o_sw_captured,
   output logic                                o_inbuf_fill_req_out,
   output logic                                o_mram_write,
   output logic [trig_pkg::BUF_IDX_W-1:0]      o_mram_buf_idx
);
   import trig_pkg::*;

   localparam int XFER_W = $clog2(XFER_CYCLES + 1);

   logic                 armed_q;
   logic                 run_q;
   logic                 tz_hit;
   logic                 mt_match;
   logic                 mt_match_q;
   logic                 cycle_ok;
   logic                 irq_set;
   ib_state_t            ib_state_q;
   logic [XFER_W-1:0]    xfer_cnt_q;

   // Cycle code: every bit set in the code must also be set in the cycle number.
   // A code of zero selects every cycle.
   always_comb begin
      cycle_ok = ((i_now.cycle & i_tz_cfg.cycle_code) ==
                  (i_tz_cfg.cycle_code & {CYCLE_W{1'b1}})) | (i_tz_cfg.cycle_code == '0);
   end // [RULE4]

   // Macrotick holds for several clocks; only the first clock of a match is a hit
   assign mt_match = (i_now.macrotick == i_tz_cfg.mt_offset); // [RULE2] [RULE5]

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         mt_match_q <= 1'b0;
      end else begin
         mt_match_q <= mt_match;
      end
   end

   // Absolute compare against macrotick within cycle
   assign tz_hit  = run_q && armed_q && cycle_ok && mt_match && !mt_match_q; // [RULE2] [RULE5]
   assign irq_set = tz_hit && !o_tz_irq;

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         run_q   <= 1'b0;
         armed_q <= 1'b0;
      end else begin
         run_q <= i_tz_cfg.run; // [RULE3]
         if (!i_tz_cfg.run) begin
            armed_q <= 1'b1;
         end else if (tz_hit && !i_tz_cfg.continuous) begin
            armed_q <= 1'b0; // [RULE3]
         end
      end
   end

   // Sticky interrupt; a hit in the clear cycle wins
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_tz_irq <= 1'b0;
      end else if (tz_hit) begin
         o_tz_irq <= 1'b1; // [RULE4]
      end else if (i_tz_irq_clear) begin
         o_tz_irq <= 1'b0;
      end
   end

   // Pulse on interrupt becoming asserted or on a hit in the clear cycle, a single clock wide
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_timer_zero_pulse_out <= 1'b0;
      end else begin
         o_timer_zero_pulse_out <= irq_set || (tz_hit && i_tz_irq_clear); // [RULE1] [RULE18]
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_tz_running <= 1'b0;
      end else begin
         o_tz_running <= run_q && armed_q;
      end
   end

   stop_watch u_stop_watch (
      .i_core_clk      (i_core_clk),
      .i_rst_n         (i_rst_n),
      .i_src_sel       (i_sw_src_sel),
      .i_soft_trig     (i_sw_soft_trig),
      .i_irq_line_zero (i_irq_line_zero),
      .i_irq_line_one  (i_irq_line_one),
      .i_ext_trig      (i_sw_ext_trig),
      .i_now           (i_now),
      .o_stamp         (o_sw_stamp),
      .o_captured      (o_sw_captured)
   ); // [RULE6] [RULE7]

   // Input staging handshake. The first command-done comes from software, so
   // the fill request is idle until then; a transfer into the message RAM
   // blocks the next request until the staging buffer is free.
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         ib_state_q           <= IB_WAIT_DONE;
         o_inbuf_fill_req_out <= 1'b0;
         o_mram_write         <= 1'b0;
         o_mram_buf_idx       <= '0;
         xfer_cnt_q           <= '0;
      end else begin
         o_inbuf_fill_req_out <= 1'b0;
         o_mram_write         <= 1'b0;
         case (ib_state_q)
            IB_FILL_REQ: begin
               o_inbuf_fill_req_out <= 1'b1; // [RULE8]
               ib_state_q           <= IB_WAIT_DONE;
            end
            IB_WAIT_DONE: begin
               if (i_inbuf_cmd_done_in) begin // [RULE9] [RULE10] [RULE12]
                  o_mram_write   <= 1'b1; // [RULE14] [RULE16]
                  o_mram_buf_idx <= i_inbuf_target; // [RULE15]
                  xfer_cnt_q     <= XFER_W'(XFER_CYCLES);
                  ib_state_q     <= IB_TRANSFER;
               end
            end
            IB_TRANSFER: begin
               if (xfer_cnt_q <= XFER_W'(1)) begin
                  ib_state_q <= IB_FILL_REQ; // [RULE17]
               end else begin
                  xfer_cnt_q <= xfer_cnt_q - XFER_W'(1);
               end
            end
            default: ib_state_q <= IB_WAIT_DONE;
         endcase
      end
   end

   chk_tz_pulse_width: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE18]
      o_timer_zero_pulse_out |=> !o_timer_zero_pulse_out)
      else $error("timer-zero pulse wider than one cycle");

   chk_tz_pulse_cause: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE1]
      tz_hit && !o_tz_irq |=> o_timer_zero_pulse_out && o_tz_irq)
      else $error("missing timer-zero pulse");

   chk_tz_no_spurious: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE1]
      $rose(o_timer_zero_pulse_out) |-> $past(tz_hit))
      else $error("pulse without timer hit");

   chk_tz_offset_match: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE5]
      tz_hit |-> i_now.macrotick == i_tz_cfg.mt_offset)
      else $error("hit away from offset");

   chk_tz_single_shot: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE3]
      tz_hit && !i_tz_cfg.continuous && i_tz_cfg.run |=> !armed_q)
      else $error("single-shot timer rearmed");

   chk_tz_stopped: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE3]
      !run_q |-> !tz_hit)
      else $error("stopped timer fired");

   chk_fill_after_done: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE17]
      ib_state_q == IB_WAIT_DONE && i_inbuf_cmd_done_in |-> ##[2:40] o_inbuf_fill_req_out)
      else $error("fill request not reissued");

   chk_fill_pulse: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE8]
      o_inbuf_fill_req_out |=> !o_inbuf_fill_req_out)
      else $error("fill request stuck");

   chk_mram_move: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE16]
      ib_state_q == IB_WAIT_DONE && i_inbuf_cmd_done_in |=> o_mram_write && o_mram_buf_idx == $past(i_inbuf_target))
      else $error("staging not moved");

   chk_tz_irq_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE4]
      o_tz_irq && !i_tz_irq_clear |=> o_tz_irq)
      else $error("timer-zero interrupt dropped without clear");

   chk_tz_run_gate: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE3]
      !i_tz_cfg.run |=> ##1 !o_tz_running)
      else $error("stopped timer still running");

   chk_mram_on_done: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE9]
      o_mram_write |-> $past(i_inbuf_cmd_done_in))
      else $error("message move without command done");

   chk_no_fill_xfer: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE17]
      ib_state_q == IB_TRANSFER |-> !o_inbuf_fill_req_out)
      else $error("fill request while staging busy");

endmodule // comm_controller_trigger_unit

// File: dma_partner.sv
`timescale 1ns/1ps
module dma_partner #(
   parameter int LAT = 3
)(
   input  wire logic                           i_core_clk,
   input  wire logic                           i_rst_n,
   input  wire logic                           i_kick,
   input  wire logic                           i_fill_req,
   input  wire logic [trig_pkg::BUF_IDX_W-1:0] i_idx,
   output logic                                o_done,
   output logic [trig_pkg::BUF_IDX_W-1:0]      o_target,
   output logic                                o_irq
);
   import trig_pkg::*;
   int                   cnt_q;
   logic [BUF_IDX_W-1:0] last_q;
   // Index is only valid with done; otherwise show a changed value
   assign o_target = o_done ? last_q : ~last_q;
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         cnt_q <= 0;
         o_done <= 1'b0;
         o_irq <= 1'b0;
      end else begin
         if (i_fill_req) begin
            cnt_q <= LAT;
         end else if (cnt_q != 0) begin
            cnt_q <= cnt_q - 1;
         end
         o_done <= i_kick | (cnt_q == 1);
         o_irq <= (cnt_q == 1);
      end
   end
   always_ff @(posedge i_core_clk) begin
      if (i_kick | (cnt_q == 1)) begin
         last_q <= i_idx;
      end
   end
endmodule // dma_partner

// File: comm_controller_trigger_unit_tb_top.sv
`timescale 1ns/1ps
module comm_controller_trigger_unit_tb_top;
   import trig_pkg::*;
   localparam int XFER = 1;
   logic                 i_core_clk, i_rst_n, clr, done, kick, clr_en, pulse, pulse_d;
   logic                 tz_irq, running, captured, fill, mwr;
   logic [3:0]           ev;
   logic [BUF_IDX_W-1:0] tgt, idx, midx;
   logic [MT_W-1:0]      mt_d;
   cycle_time_t          now, stamp;
   tz_cfg_t              cfg;
   sw_src_t              sel;
   int                   err_count, tests_run, cyc, npulse, gap;

   comm_controller_trigger_unit #(.XFER_CYCLES(XFER)) comm_controller_trigger_unit_inst (
      .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_now(now), .i_tz_cfg(cfg), .i_tz_irq_clear(clr),
      .i_sw_src_sel(sel), .i_sw_soft_trig(ev[0]), .i_irq_line_zero(ev[1]), .i_irq_line_one(ev[2]),
      .i_sw_ext_trig(ev[3]), .i_inbuf_cmd_done_in(done), .i_inbuf_target(tgt),
      .o_timer_zero_pulse_out(pulse), .o_tz_irq(tz_irq), .o_tz_running(running), .o_sw_stamp(stamp),
      .o_sw_captured(captured), .o_inbuf_fill_req_out(fill), .o_mram_write(mwr), .o_mram_buf_idx(midx));
   dma_partner #(.LAT(3)) dma_partner_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_kick(kick),
      .i_fill_req(fill), .i_idx(idx), .o_done(done), .o_target(tgt), .o_irq());

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end
   // Free-running time base, 32 macroticks per cycle
   always @(negedge i_core_clk) begin
      now <= (now.macrotick == 14'h001F) ? {now.cycle + 6'h01, 14'h0000} : {now.cycle, now.macrotick + 14'h0001};
      clr <= clr_en & tz_irq;
   end
   always @(posedge i_core_clk) begin
      cyc <= cyc + 1;
      pulse_d <= pulse;
      mt_d <= now.macrotick;
      if (cyc >= 20000) begin
         err_count++;
         end_sim();
      end
      if (pulse) begin
         npulse++;
         check(mt_d, 14'h0010);
         check(pulse_d, 1'b0);
      end
   end
   task automatic sw_fire(input logic [3:0] e, input logic exp);
      cycle_time_t t;
      @(negedge i_core_clk) ev = e;
      @(posedge i_core_clk) t = now;
      @(negedge i_core_clk) ev = 4'h0;
      check(captured, exp);
      if (exp) check(stamp, t);
   endtask
   task automatic tz_case(input logic run, input logic cont, input logic [5:0] code, input int exp);
      @(negedge i_core_clk) cfg.run = 1'b0;
      do @(posedge i_core_clk); while (now.macrotick != 14'h001F);
      @(negedge i_core_clk) cfg = {run, cont, code, 14'h0010};
      npulse = 0;
      repeat (128) @(posedge i_core_clk);
      @(negedge i_core_clk) check(npulse, exp);
      check(running, run & cont);
   endtask
   task automatic ib_xfer(input logic [6:0] v);
      idx = v;
      gap = 0;
      while (mwr !== 1'b1 && gap < 50) begin
         @(posedge i_core_clk) #1 gap++;
      end
      check(mwr, 1'b1);
      check(midx, v);
      gap = 0;
      do @(posedge i_core_clk) #1 gap++; while (fill !== 1'b1 && gap < 50);
      check(gap, XFER + 1);
   endtask
   initial begin
      {i_rst_n, clr, kick, clr_en, cyc, err_count, tests_run, npulse} = '0;
      {ev, idx, now, cfg, pulse_d, mt_d} = '0;
      sel = SW_SRC_SOFT;
      repeat (16) @(posedge i_core_clk);
      @(negedge i_core_clk) i_rst_n = 1'b1;
      for (int s = 0; s < 4; s++) begin
         sel = sw_src_t'(s);
         sw_fire(~(4'h1 << s), 1'b0);
         sw_fire(4'h1 << s, 1'b1);
         sw_fire(4'h1 << s, 1'b1);
      end
      $display("test stop watch done");
      clr_en = 1'b1;
      tz_case(1'b1, 1'b0, 6'h00, 1);
      tz_case(1'b1, 1'b1, 6'h00, 4);
      tz_case(1'b1, 1'b1, 6'h01, 2);
      tz_case(1'b1, 1'b1, 6'h03, 1);
      tz_case(1'b0, 1'b1, 6'h00, 0);
      clr_en = 1'b0;
      tz_case(1'b1, 1'b1, 6'h00, 1);
      check(tz_irq, 1'b1);
      $display("test timer zero done");
      idx = 7'h2A;
      kick = 1'b1;
      @(negedge i_core_clk) kick = 1'b0;
      ib_xfer(7'h2A);
      ib_xfer(7'h00);
      ib_xfer(7'h7F);
      $display("test input buffer done");
      end_sim();
   end
endmodule // comm_controller_trigger_unit_tb_top
